// [hdl/qseq_consts.svh]
/*
 Constants of the status and error queue block: bit positions, masks,
 reset and preset values, queue figures.
 Assumes inclusion by bare name from the design files and the test bench.
*/
`ifndef QSEQ_CONSTS_SVH
`define QSEQ_CONSTS_SVH

// Summary bit positions in the top register
`define QSEQ_VOLT_BIT 0
`define QSEQ_TEMP_BIT 4
// Implemented bits of each register
`define QSEQ_SUM_IMPL 16'h0011
`define QSEQ_VOLT_IMPL 16'h0003
`define QSEQ_TEMP_IMPL 16'h0001
// Sub-register trip bits
`define QSEQ_OV_BIT 0
`define QSEQ_UV_BIT 1
`define QSEQ_OT_BIT 0
// Reset values of the host-written masks
`define QSEQ_ENABLE_RST 16'h0000
`define QSEQ_PTR_RST 16'hFFFF
`define QSEQ_NTR_RST 16'h0000
// Preset values of the summary register masks
`define QSEQ_ENABLE_PRE 16'h0000
`define QSEQ_PTR_PRE 16'hFFFF
`define QSEQ_NTR_PRE 16'h0000
// Queue figures
`define QSEQ_DEPTH 3'h4
`define QSEQ_NO_ERROR 16'h0000
`define QSEQ_OVF_CODE 16'hFEA2
`define QSEQ_OVF_TEXT 8'h0E
`define QSEQ_NOERR_TEXT 8'h08

`endif

// [hdl/qseq_pkg.sv]
/*
 Types of the status and error queue block: command, answer and entry carriers.
 Assumes the constants header sits beside it.
*/
package qseq_pkg;
	// Host operations
	typedef enum logic [3:0] {
		QSEQ_OP_RD_EVENT = 4'h0,
		QSEQ_OP_RD_COND = 4'h1,
		QSEQ_OP_WR_ENABLE = 4'h2,
		QSEQ_OP_RD_ENABLE = 4'h3,
		QSEQ_OP_WR_PTR = 4'h4,
		QSEQ_OP_RD_PTR = 4'h5,
		QSEQ_OP_WR_NTR = 4'h6,
		QSEQ_OP_RD_NTR = 4'h7,
		QSEQ_OP_ERR_NEXT = 4'h8,
		QSEQ_OP_ERR_CODE = 4'h9,
		QSEQ_OP_ERR_COUNT = 4'hA,
		QSEQ_OP_CLEAR = 4'hB,
		QSEQ_OP_PRESET = 4'hC
	} qseq_op_t;
	// Register selected by a status operation
	typedef enum logic [1:0] {
		QSEQ_TGT_SUM = 2'h0,
		QSEQ_TGT_VOLT = 2'h1,
		QSEQ_TGT_TEMP = 2'h2
	} qseq_tgt_t;
	typedef struct packed {
		logic valid;
		qseq_op_t op;
		qseq_tgt_t tgt;
		logic [15:0] data;
	} qseq_cmd_t;
	typedef struct packed {
		logic valid;
		logic neg;
		logic [19:0] bcd;
		logic [15:0] value;
		logic [7:0] textLen;
	} qseq_rsp_t;
	// Error report from the rest of the device
	typedef struct packed {
		logic valid;
		logic signed [15:0] code;
		logic [7:0] textLen;
	} qseq_err_t;
	// Write strobes into one status register
	typedef struct packed {
		logic enable;
		logic ptr;
		logic ntr;
		logic evRead;
		logic clear;
		logic preset;
		logic [15:0] data;
	} qseq_wr_t;
	typedef struct packed {
		logic [15:0] evt;
		logic [15:0] cond;
		logic [15:0] enable;
		logic [15:0] ptr;
		logic [15:0] ntr;
	} qseq_regs_t;
endpackage

// [hdl/qseq_event_reg.sv]
/*
 One status register: condition, transition filters, latched event, enable, summary.
 Assumes a condition vector in the clk domain and one-cycle write strobes.
*/
`include "qseq_consts.svh"

module qseq_event_reg #(
	parameter logic [15:0] IMPL = 16'hFFFF
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Live condition
	input wire logic [15:0] cond,
	// Host access
	input wire qseq_pkg::qseq_wr_t wr,
	output qseq_pkg::qseq_regs_t regs,
	output logic summary
);
	import qseq_pkg::*;

	logic [15:0] condNow;
	logic [15:0] rise;
	logic [15:0] fall;
	logic [15:0] condReg;
	logic [15:0] evtReg;
	logic [15:0] enableReg;
	logic [15:0] ptrReg;
	logic [15:0] ntrReg;

	// One driver for the whole register view
	assign regs = '{evt: evtReg, cond: condReg, enable: enableReg, ptr: ptrReg, ntr: ntrReg};

	// Filtered transitions against the stored condition
	assign condNow = cond & IMPL;
	assign rise = condNow & ~condReg & ptrReg;
	assign fall = ~condNow & condReg & ntrReg;

	// Condition snapshot
	always_ff @(posedge clk) begin
		if (rst) begin
			condReg <= 16'h0000;
		end else begin
			condReg <= condNow;
		end
	end

	// Latched events, a new transition beats a clear
	always_ff @(posedge clk) begin
		if (rst) begin
			evtReg <= 16'h0000;
		end else if (wr.clear || wr.evRead) begin
			evtReg <= rise | fall;
		end else begin
			evtReg <= evtReg | rise | fall;
		end
	end

	// Host masks, unimplemented bits held at zero
	always_ff @(posedge clk) begin
		if (rst) begin
			enableReg <= `QSEQ_ENABLE_RST & IMPL;
			ptrReg <= `QSEQ_PTR_RST & IMPL;
			ntrReg <= `QSEQ_NTR_RST & IMPL;
		end else if (wr.preset) begin
			enableReg <= `QSEQ_ENABLE_PRE & IMPL;
			ptrReg <= `QSEQ_PTR_PRE & IMPL;
			ntrReg <= `QSEQ_NTR_PRE & IMPL;
		end else begin
			if (wr.enable) begin
				enableReg <= wr.data & IMPL;
			end
			if (wr.ptr) begin
				ptrReg <= wr.data & IMPL;
			end
			if (wr.ntr) begin
				ntrReg <= wr.data & IMPL;
			end
		end
	end

	// Summary is the OR of enabled events
	always_ff @(posedge clk) begin
		if (rst) begin
			summary <= 1'b0;
		end else begin
			summary <= |(evtReg & enableReg);
		end
	end

	// Checks
	property p_rise_latch;
		@(posedge clk) disable iff (rst)
		(rise != 16'h0000) |=> ((regs.evt & $past(rise)) == $past(rise));
	endproperty
	a_rise_latch: assert property (p_rise_latch) else $error("rise lost");
	property p_summary_or;
		@(posedge clk) disable iff (rst)
		##1 summary == (|($past(regs.evt) & $past(regs.enable)));
	endproperty
	a_summary_or: assert property (p_summary_or) else $error("bad summary");
	property p_unimpl_zero;
		@(posedge clk) disable iff (rst)
		((regs.evt | regs.cond | regs.enable | regs.ptr | regs.ntr) & ~IMPL) == 16'h0000;
	endproperty
	a_unimpl_zero: assert property (p_unimpl_zero) else $error("unused bit set");
	property p_preset_keeps_evt;
		@(posedge clk) disable iff (rst)
		wr.preset && !wr.clear && !wr.evRead |=> regs.enable == (`QSEQ_ENABLE_PRE & IMPL)
			&& ((regs.evt & $past(regs.evt)) == $past(regs.evt));
	endproperty
	a_preset_keeps_evt: assert property (p_preset_keeps_evt) else $error("bad preset");
endmodule

// [hdl/qseq_status_queue.sv]
/*
 Status summary tree with voltage and temperature sub-registers, and a
 four-entry error/event queue, driven by decoded host status commands.
 Assumes trip pins are asynchronous, error reports and commands come from clk logic.
*/
// What this block does
// - Sixteen-bit summary register for doubtful output
// - Bit 0 summarises the voltage sub-register
// - Bit 4 summarises the temperature sub-register
// - Summary is OR of enabled events
// - Voltage bits: over trip 0, under 1
// - Temperature bit 0 flags over-temperature
// - Host reads event, condition; writes masks, filters
// - Entries carry signed sixteen-bit codes
// - Code zero means none, never stored
// - Entry text length at most 255
// - Entries leave in arrival order
// - Queue holds at most four entries
// - Overflow keeps old, last becomes -350
// - Queue bit set while entries remain
// - Full query returns oldest, removes it
// - Code query returns code, removes entry
// - Count query leaves queue untouched
// - Register answers given in decimal
// - Clear empties events and queue
// - Preset sets summary masks, keeps events
`include "qseq_consts.svh"

module qseq_status_queue (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Trip pins
	input wire logic overVoltageTrip,
	input wire logic underVoltageTrip,
	input wire logic overTempTrip,
	// Error reports
	input wire qseq_pkg::qseq_err_t errIn,
	// Host commands and answers
	input wire qseq_pkg::qseq_cmd_t cmd,
	output qseq_pkg::qseq_rsp_t rsp,
	// Status byte feeds
	output logic errQueueBit,
	output logic summaryBit
);
	import qseq_pkg::*;

	// Decode of a status operation on one register
	function automatic logic hits(input qseq_cmd_t c, input qseq_op_t o, input int idx);
		return c.valid && c.op == o && c.tgt == qseq_tgt_t'(idx[1:0]);
	endfunction

	// Binary to five decimal digits
	function automatic logic [19:0] toDecimal(input logic [15:0] bin);
		logic [35:0] sh;
		sh = {20'h00000, bin};
		for (int i = 0; i < 16; i++) begin
			for (int d = 0; d < 5; d++) begin
				if (sh[16 + 4 * d +: 4] > 4'h4) begin
					sh[16 + 4 * d +: 4] = sh[16 + 4 * d +: 4] + 4'h3;
				end
			end
			sh = {sh[34:0], 1'b0};
		end
		return sh[35:16];
	endfunction

	// Trip pin synchronisers
	logic [2:0] tripMeta;
	logic [2:0] tripSync;

	always_ff @(posedge clk) begin
		if (rst) begin
			tripMeta <= 3'h0;
			tripSync <= 3'h0;
		end else begin
			tripMeta <= {overTempTrip, underVoltageTrip, overVoltageTrip};
			tripSync <= tripMeta;
		end
	end

	// Status register tree
	logic [15:0] condIn [3];
	qseq_wr_t wr [3];
	qseq_regs_t regs [3];
	logic summaries [3];
	logic [15:0] voltCond;
	logic [15:0] tempCond;
	logic [15:0] sumCond;

	// Conditions of each register
	always_comb begin
		voltCond = 16'h0000;
		voltCond[`QSEQ_OV_BIT] = tripSync[0];
		voltCond[`QSEQ_UV_BIT] = tripSync[1];
		tempCond = 16'h0000;
		tempCond[`QSEQ_OT_BIT] = tripSync[2];
		sumCond = 16'h0000;
		sumCond[`QSEQ_VOLT_BIT] = summaries[1];
		sumCond[`QSEQ_TEMP_BIT] = summaries[2];
	end

	assign condIn[0] = sumCond;
	assign condIn[1] = voltCond;
	assign condIn[2] = tempCond;

	// Three instances, the summary register first
	for (genvar g = 0; g < 3; g++) begin : gRegs
		localparam logic [15:0] MASK = (g == 0) ? `QSEQ_SUM_IMPL :
			(g == 1) ? `QSEQ_VOLT_IMPL : `QSEQ_TEMP_IMPL;

		// Write strobes for this register
		always_comb begin
			wr[g].enable = hits(cmd, QSEQ_OP_WR_ENABLE, g);
			wr[g].ptr = hits(cmd, QSEQ_OP_WR_PTR, g);
			wr[g].ntr = hits(cmd, QSEQ_OP_WR_NTR, g);
			wr[g].evRead = hits(cmd, QSEQ_OP_RD_EVENT, g);
			wr[g].clear = cmd.valid && cmd.op == QSEQ_OP_CLEAR;
			wr[g].preset = (g == 0) && cmd.valid && cmd.op == QSEQ_OP_PRESET;
			wr[g].data = cmd.data;
		end

		qseq_event_reg #(
			.IMPL(MASK)
		) uReg (
			.clk(clk),
			.rst(rst),
			.cond(condIn[g]),
			.wr(wr[g]),
			.regs(regs[g]),
			.summary(summaries[g])
		);
	end

	// Summary register sits on the status byte
	always_ff @(posedge clk) begin
		if (rst) begin
			summaryBit <= 1'b0;
		end else begin
			summaryBit <= summaries[0];
		end
	end

	// Error queue storage
	logic [15:0] codes [4];
	logic [7:0] lens [4];
	logic [1:0] head;
	logic [2:0] count;
	logic [2:0] next_count;
	logic isClear;
	logic push;
	logic pop;
	logic pushStore;
	logic overflow;
	logic [1:0] tail;
	logic [1:0] lastSlot;

	// Queue traffic this cycle
	always_comb begin
		isClear = cmd.valid && cmd.op == QSEQ_OP_CLEAR;
		push = errIn.valid && errIn.code != `QSEQ_NO_ERROR;
		pop = cmd.valid && (cmd.op == QSEQ_OP_ERR_NEXT || cmd.op == QSEQ_OP_ERR_CODE)
			&& count != 3'h0 && !isClear;
		pushStore = push && (count != `QSEQ_DEPTH || pop);
		overflow = push && count == `QSEQ_DEPTH && !pop && !isClear;
		tail = head + count[1:0];
		lastSlot = head + 2'h3;
		if (isClear) begin
			next_count = push ? 3'h1 : 3'h0;
		end else begin
			next_count = count + {2'h0, pushStore} - {2'h0, pop};
		end
	end

	// Head and fill level
	always_ff @(posedge clk) begin
		if (rst) begin
			head <= 2'h0;
			count <= 3'h0;
		end else begin
			count <= next_count;
			if (isClear) begin
				head <= 2'h0;
			end else if (pop) begin
				head <= head + 2'h1;
			end
		end
	end

	// Entry writes: new entry at tail, overflow marks last slot
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < 4; i++) begin
				codes[i] <= `QSEQ_NO_ERROR;
				lens[i] <= 8'h00;
			end
		end else if (isClear && push) begin
			codes[0] <= errIn.code;
			lens[0] <= errIn.textLen;
		end else if (overflow) begin
			codes[lastSlot] <= `QSEQ_OVF_CODE;
			lens[lastSlot] <= `QSEQ_OVF_TEXT;
		end else if (pushStore && !isClear) begin
			codes[tail] <= errIn.code;
			lens[tail] <= errIn.textLen;
		end
	end

	// Error-queue bit of the status byte
	always_ff @(posedge clk) begin
		if (rst) begin
			errQueueBit <= 1'b0;
		end else begin
			errQueueBit <= next_count != 3'h0;
		end
	end

	// Answer selection
	qseq_rsp_t next_rsp;
	qseq_regs_t sel;
	logic [15:0] mag;

	always_comb begin
		sel = regs[0];
		if (cmd.tgt == QSEQ_TGT_VOLT) begin
			sel = regs[1];
		end else if (cmd.tgt == QSEQ_TGT_TEMP) begin
			sel = regs[2];
		end
		next_rsp = '0;
		next_rsp.valid = cmd.valid;
		unique case (cmd.op)
			QSEQ_OP_RD_EVENT: next_rsp.value = sel.evt;
			QSEQ_OP_RD_COND: next_rsp.value = sel.cond;
			QSEQ_OP_RD_ENABLE: next_rsp.value = sel.enable;
			QSEQ_OP_RD_PTR: next_rsp.value = sel.ptr;
			QSEQ_OP_RD_NTR: next_rsp.value = sel.ntr;
			QSEQ_OP_ERR_NEXT: begin
				next_rsp.value = pop ? codes[head] : `QSEQ_NO_ERROR;
				next_rsp.textLen = pop ? lens[head] : `QSEQ_NOERR_TEXT;
			end
			QSEQ_OP_ERR_CODE: next_rsp.value = pop ? codes[head] : `QSEQ_NO_ERROR;
			QSEQ_OP_ERR_COUNT: next_rsp.value = {13'h0000, count};
			default: next_rsp.valid = 1'b0;
		endcase
		if (cmd.tgt == 2'h3 && cmd.op <= QSEQ_OP_RD_NTR) begin
			next_rsp.valid = 1'b0;
		end
		next_rsp.neg = (cmd.op == QSEQ_OP_ERR_NEXT || cmd.op == QSEQ_OP_ERR_CODE)
			&& next_rsp.value[15];
		mag = next_rsp.neg ? (~next_rsp.value + 16'h0001) : next_rsp.value;
		next_rsp.bcd = toDecimal(mag);
	end

	// Registered answer
	always_ff @(posedge clk) begin
		if (rst) begin
			rsp <= '0;
		end else begin
			rsp <= next_rsp;
		end
	end

	// Checks
	property p_depth;
		@(posedge clk) disable iff (rst)
		count <= `QSEQ_DEPTH;
	endproperty
	a_depth: assert property (p_depth) else $error("queue too deep");
	property p_zero_dropped;
		@(posedge clk) disable iff (rst)
		errIn.valid && errIn.code == `QSEQ_NO_ERROR && !pop && !isClear |=>
			count == $past(count);
	endproperty
	a_zero_dropped: assert property (p_zero_dropped) else $error("zero stored");
	property p_overflow;
		@(posedge clk) disable iff (rst)
		overflow |=> count == `QSEQ_DEPTH && codes[$past(lastSlot)] == `QSEQ_OVF_CODE
			&& codes[head] == $past(codes[head]);
	endproperty
	a_overflow: assert property (p_overflow) else $error("overflow wrong");
	property p_oldest_first;
		@(posedge clk) disable iff (rst)
		pop |=> rsp.valid && rsp.value == $past(codes[head]) && head == $past(head) + 2'h1;
	endproperty
	a_oldest_first: assert property (p_oldest_first) else $error("not oldest");
	property p_err_bit;
		@(posedge clk) disable iff (rst)
		errQueueBit == (count != 3'h0);
	endproperty
	a_err_bit: assert property (p_err_bit) else $error("queue bit wrong");
	property p_count_query;
		@(posedge clk) disable iff (rst)
		cmd.valid && cmd.op == QSEQ_OP_ERR_COUNT && !push |=>
			rsp.value == {13'h0000, $past(count)} && count == $past(count);
	endproperty
	a_count_query: assert property (p_count_query) else $error("count wrong");
	property p_empty_query;
		@(posedge clk) disable iff (rst)
		cmd.valid && cmd.op == QSEQ_OP_ERR_NEXT && count == 3'h0 && !push |=>
			rsp.value == 16'h0000 && rsp.textLen == `QSEQ_NOERR_TEXT && count == 3'h0;
	endproperty
	a_empty_query: assert property (p_empty_query) else $error("empty answer wrong");
	property p_clear;
		@(posedge clk) disable iff (rst)
		isClear && !push |=> count == 3'h0 && !errQueueBit;
	endproperty
	a_clear: assert property (p_clear) else $error("clear failed");
	property p_decimal;
		@(posedge clk) disable iff (rst)
		rsp.valid && !rsp.neg && rsp.value == 16'h0011 |-> rsp.bcd == 20'h00017;
	endproperty
	a_decimal: assert property (p_decimal) else $error("bad decimal");
	property p_volt_summary;
		@(posedge clk) disable iff (rst)
		regs[0].cond[`QSEQ_VOLT_BIT] == $past(summaries[1]);
	endproperty
	a_volt_summary: assert property (p_volt_summary) else $error("bit 0 wrong");
	c_overflow: cover property (@(posedge clk) disable iff (rst) overflow);
	c_pop_full: cover property (@(posedge clk) disable iff (rst) pop && count == `QSEQ_DEPTH);
	c_clear_push: cover property (@(posedge clk) disable iff (rst) isClear && push);
	c_summary: cover property (@(posedge clk) disable iff (rst) $rose(summaryBit));
endmodule

// [tb/qseq_host_model.sv]
/*
 Host model: issues status and error commands and collects the answers.
 Assumes the block's clock and that commands change on its falling edge.
*/
module qseq_host_model (
	// Clock
	input wire logic clk,
	// Command out, answer in
	output qseq_pkg::qseq_cmd_t cmd,
	input wire qseq_pkg::qseq_rsp_t rsp
);
	timeunit 1ns;
	timeprecision 100ps;
	import qseq_pkg::*;

	// Idle until a command is asked for
	initial cmd = '0;

	// One command pulse, answer taken half a cycle after the taking edge
	task automatic issue(input qseq_op_t op, input qseq_tgt_t tgt, input logic [15:0] d,
		output qseq_rsp_t ans);
		@(negedge clk);
		cmd <= '{1'b1, op, tgt, d};
		@(negedge clk);
		ans = rsp;
		cmd <= '0;
	endtask
endmodule

// [tb/qseq_status_queue_test.sv]
/*
 Self-checking bench of the status summary and error queue block.
 Assumes the host model beside it and the package and constants header on the path.
*/
`include "qseq_consts.svh"

module qseq_status_queue_test;
	timeunit 1ns;
	timeprecision 100ps;
	import qseq_pkg::*;

	logic clk = 1'b0;
	logic rst = 1'b1;
	logic overVoltageTrip = 1'b0;
	logic underVoltageTrip = 1'b0;
	logic overTempTrip = 1'b0;
	qseq_err_t errIn = '0;
	qseq_cmd_t cmd;
	qseq_rsp_t rsp;
	qseq_rsp_t ans;
	logic errQueueBit;
	logic summaryBit;
	int errors = 0;
	int totalChecks = 0;
	int cycles = 0;
	logic [23:0] model[$];
	logic [15:0] impl[3] = '{`QSEQ_SUM_IMPL, `QSEQ_VOLT_IMPL, `QSEQ_TEMP_IMPL};

	// Clock and hang guard
	always #2 clk = ~clk;
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errors = errors + 1;
			end_of_test();
		end
	end

	qseq_status_queue dut (
		.clk(clk),
		.rst(rst),
		.overVoltageTrip(overVoltageTrip),
		.underVoltageTrip(underVoltageTrip),
		.overTempTrip(overTempTrip),
		.errIn(errIn),
		.cmd(cmd),
		.rsp(rsp),
		.errQueueBit(errQueueBit),
		.summaryBit(summaryBit)
	);

	qseq_host_model host (
		.clk(clk),
		.cmd(cmd),
		.rsp(rsp)
	);

	// Verdict and end of run
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", totalChecks, errors);
		if (errors == 0 && totalChecks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Compare and report
	task automatic check(input logic [47:0] got, input logic [47:0] exp, input string what);
		totalChecks++;
		if (got !== exp) begin
			errors++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic note(input string name);
		$display("test %s done", name);
	endtask

	// Five decimal digits of a magnitude
	function automatic logic [19:0] toBcd(input logic [15:0] v);
		logic [19:0] r;
		int n;
		r = '0;
		n = v;
		for (int i = 0; i < 5; i++) begin
			r[i*4+:4] = 4'(n % 10);
			n = n / 10;
		end
		return r;
	endfunction

	// Whole expected answer word: valid, sign, digits, raw value, text length
	function automatic logic [47:0] expAns(input logic [15:0] v, input logic n,
		input logic [7:0] t);
		logic [15:0] m;
		m = n ? 16'(-v) : v;
		return {2'b00, 1'b1, n, toBcd(m), v, t};
	endfunction

	// Host accesses
	task automatic rd(input qseq_op_t op, input qseq_tgt_t tg, input logic [47:0] exp);
		host.issue(op, tg, 16'h0000, ans);
		check({2'b00, ans}, exp, "answer");
	endtask
	task automatic regRd(input qseq_op_t op, input qseq_tgt_t tg, input logic [15:0] v);
		rd(op, tg, expAns(v, 1'b0, 8'h00));
	endtask
	task automatic wr(input qseq_op_t op, input qseq_tgt_t tg, input logic [15:0] d);
		host.issue(op, tg, d, ans);
		check({47'h0, ans.valid}, 48'h0, "write answered");
	endtask
	task automatic bitChk(input logic got, input logic exp);
		check({47'h0, got}, {47'h0, exp}, "status bit");
	endtask

	// Trip pins change, then settle through sync and summary stages
	task automatic trips(input logic [2:0] p);
		@(negedge clk);
		{overVoltageTrip, underVoltageTrip, overTempTrip} <= p;
		repeat (10) @(negedge clk);
	endtask

	// Error report and its expected effect on the queue
	task automatic push(input logic [15:0] c, input logic [7:0] t);
		@(negedge clk);
		errIn <= '{1'b1, c, t};
		@(negedge clk);
		errIn <= '0;
		if (c != 16'h0000) begin
			if (model.size() < `QSEQ_DEPTH) begin
				model.push_back({c, t});
			end else begin
				model[3] = {`QSEQ_OVF_CODE, `QSEQ_OVF_TEXT};
			end
		end
	endtask
	task automatic pop(input logic full);
		logic [23:0] e;
		e = model.pop_front();
		if (full) begin
			rd(QSEQ_OP_ERR_NEXT, QSEQ_TGT_SUM, expAns(e[23:8], e[23], e[7:0]));
		end else begin
			rd(QSEQ_OP_ERR_CODE, QSEQ_TGT_SUM, expAns(e[23:8], e[23], 8'h00));
		end
	endtask
	task automatic count();
		rd(QSEQ_OP_ERR_COUNT, QSEQ_TGT_SUM, expAns(16'(model.size()), 1'b0, 8'h00));
	endtask

	// Main sequence
	initial begin
		int k;
		logic [15:0] d;
		qseq_op_t op;
		qseq_tgt_t tg;
		k = $urandom(32'h9E576D85);
		repeat (16) @(negedge clk);
		rst <= 1'b0;
		@(negedge clk);
		bitChk(errQueueBit, 1'b0);
		bitChk(summaryBit, 1'b0);
		for (int i = 0; i < 3; i++) begin
			tg = qseq_tgt_t'(i);
			regRd(QSEQ_OP_RD_ENABLE, tg, `QSEQ_ENABLE_RST);
			regRd(QSEQ_OP_RD_PTR, tg, `QSEQ_PTR_RST & impl[i]);
			regRd(QSEQ_OP_RD_NTR, tg, `QSEQ_NTR_RST);
			regRd(QSEQ_OP_RD_EVENT, tg, 16'h0000);
		end
		// Register select 3 is refused: no answer, no write lands
		wr(QSEQ_OP_RD_ENABLE, qseq_tgt_t'(2'h3), 16'h0000);
		wr(QSEQ_OP_WR_ENABLE, qseq_tgt_t'(2'h3), 16'hFFFF);
		regRd(QSEQ_OP_RD_ENABLE, QSEQ_TGT_SUM, `QSEQ_ENABLE_RST);
		regRd(QSEQ_OP_RD_ENABLE, QSEQ_TGT_TEMP, `QSEQ_ENABLE_RST);
		note("reset values");
		// Random mask writes, read back through the implemented bits
		for (int i = 0; i < 12; i++) begin
			k = $urandom_range(2);
			tg = qseq_tgt_t'(i % 3);
			op = qseq_op_t'(2 + 2 * k);
			d = 16'($urandom);
			wr(op, tg, d);
			regRd(qseq_op_t'(3 + 2 * k), tg, d & impl[i % 3]);
			wr(op, tg, k == 1 ? 16'hFFFF : 16'h0000);
		end
		note("mask access");
		// Trips feed sub-registers and the summary tree
		trips(3'b100);
		regRd(QSEQ_OP_RD_COND, QSEQ_TGT_VOLT, 16'h0001);
		bitChk(summaryBit, 1'b0);
		wr(QSEQ_OP_WR_ENABLE, QSEQ_TGT_VOLT, 16'h0003);
		wr(QSEQ_OP_WR_ENABLE, QSEQ_TGT_TEMP, 16'h0001);
		wr(QSEQ_OP_WR_ENABLE, QSEQ_TGT_SUM, 16'h0011);
		repeat (6) @(negedge clk);
		bitChk(summaryBit, 1'b1);
		regRd(QSEQ_OP_RD_COND, QSEQ_TGT_SUM, 16'h0001);
		regRd(QSEQ_OP_RD_EVENT, QSEQ_TGT_SUM, 16'h0001);
		regRd(QSEQ_OP_RD_EVENT, QSEQ_TGT_VOLT, 16'h0001);
		repeat (6) @(negedge clk);
		bitChk(summaryBit, 1'b0);
		trips(3'b111);
		regRd(QSEQ_OP_RD_EVENT, QSEQ_TGT_SUM, 16'h0011);
		regRd(QSEQ_OP_RD_COND, QSEQ_TGT_VOLT, 16'h0003);
		regRd(QSEQ_OP_RD_EVENT, QSEQ_TGT_VOLT, 16'h0002);
		regRd(QSEQ_OP_RD_COND, QSEQ_TGT_TEMP, 16'h0001);
		regRd(QSEQ_OP_RD_EVENT, QSEQ_TGT_TEMP, 16'h0001);
		trips(3'b000);
		regRd(QSEQ_OP_RD_EVENT, QSEQ_TGT_VOLT, 16'h0000);
		note("summary tree");
		// Queue: empty answers, extremes, overflow, ordered drain
		rd(QSEQ_OP_ERR_NEXT, QSEQ_TGT_SUM, expAns(16'h0000, 1'b0, `QSEQ_NOERR_TEXT));
		rd(QSEQ_OP_ERR_CODE, QSEQ_TGT_SUM, expAns(16'h0000, 1'b0, 8'h00));
		push(16'h0000, 8'h05);
		count();
		push(16'h8000, 8'hFF);
		push(16'h7FFF, 8'h00);
		for (int i = 0; i < 4; i++) begin
			push(16'($urandom_range(16'hFFFF, 1)), 8'($urandom));
		end
		bitChk(errQueueBit, 1'b1);
		count();
		count();
		while (model.size() > 0) begin
			pop(model.size() % 2 == 1);
			count();
		end
		bitChk(errQueueBit, 1'b0);
		note("error queue");
		// Clear empties events and queue; preset touches only summary masks
		push(16'h0015, 8'h03);
		trips(3'b100);
		wr(QSEQ_OP_CLEAR, QSEQ_TGT_SUM, 16'h0000);
		model.delete();
		count();
		bitChk(errQueueBit, 1'b0);
		regRd(QSEQ_OP_RD_EVENT, QSEQ_TGT_VOLT, 16'h0000);
		// A report arriving with the clear is kept as the only entry
		fork
			push(16'h0021, 8'h04);
			wr(QSEQ_OP_CLEAR, QSEQ_TGT_SUM, 16'h0000);
		join
		count();
		pop(1'b1);
		wr(QSEQ_OP_WR_PTR, QSEQ_TGT_SUM, 16'h0000);
		wr(QSEQ_OP_WR_NTR, QSEQ_TGT_SUM, 16'hFFFF);
		trips(3'b110);
		wr(QSEQ_OP_PRESET, QSEQ_TGT_SUM, 16'h0000);
		regRd(QSEQ_OP_RD_ENABLE, QSEQ_TGT_SUM, `QSEQ_ENABLE_PRE);
		regRd(QSEQ_OP_RD_PTR, QSEQ_TGT_SUM, `QSEQ_PTR_PRE & `QSEQ_SUM_IMPL);
		regRd(QSEQ_OP_RD_NTR, QSEQ_TGT_SUM, `QSEQ_NTR_PRE);
		regRd(QSEQ_OP_RD_ENABLE, QSEQ_TGT_VOLT, 16'h0003);
		regRd(QSEQ_OP_RD_EVENT, QSEQ_TGT_VOLT, 16'h0002);
		note("clear and preset");
		end_of_test();
	end
endmodule
